// file: hw/addr_map_pkg.sv
package addr_map_pkg;
    localparam int ADDR_W = 32;
    localparam int EXT_DATA_W = 16;
    // Region bases and sizes, byte addresses
    localparam logic [31:0] SDRAM_BASE = 32'h0000_0000;
    localparam logic [31:0] SDRAM_MAX_BYTES = 32'h0800_0000;
    localparam logic [31:0] ASYNC_BASE = 32'h2000_0000;
    localparam logic [31:0] ASYNC_SEG_BYTES = 32'h0010_0000;
    localparam int ASYNC_BANKS = 4;
    localparam logic [31:0] BOOT_ROM_BASE = 32'hEF00_0000;
    localparam logic [31:0] BOOT_ROM_BYTES = 32'h0000_8000;
    localparam logic [31:0] DATA_A_BASE = 32'hFF80_0000;
    localparam logic [31:0] DATA_B_BASE = 32'hFF90_0000;
    localparam logic [31:0] DATA_BANK_BYTES = 32'h0000_8000;
    localparam logic [31:0] INSTR_BASE = 32'hFFA0_0000;
    localparam logic [31:0] INSTR_BYTES = 32'h0000_C000;
    // Cacheable window is the top 16K of the instruction region
    localparam logic [31:0] INSTR_CACHE_BASE = 32'hFFA0_8000;
    localparam logic [31:0] INSTR_CACHE_BYTES = 32'h0000_4000;
    localparam logic [31:0] SCRATCH_BASE = 32'hFFB0_0000;
    localparam logic [31:0] SCRATCH_BYTES = 32'h0000_1000;
    localparam logic [31:0] PERIPH_REG_BASE = 32'hFFC0_0000;
    localparam logic [31:0] CORE_REG_BASE = 32'hFFE0_0000;
    localparam logic [31:0] REG_BLOCK_BYTES = 32'h0020_0000;
    localparam int SDRAM_INT_BANKS = 4;
    localparam int ROW_W = 13;
    localparam logic [31:0] RESET_FETCH_ROM = BOOT_ROM_BASE;
    localparam logic [31:0] RESET_FETCH_EXT = ASYNC_BASE;

    typedef enum logic [3:0] {
        TGT_NONE = 4'h0,
        TGT_INSTR = 4'h1,
        TGT_DATA_A = 4'h2,
        TGT_DATA_B = 4'h3,
        TGT_SCRATCH = 4'h4,
        TGT_CORE_REG = 4'h5,
        TGT_PERIPH_REG = 4'h6,
        TGT_SDRAM = 4'h7,
        TGT_ASYNC = 4'h8,
        TGT_BOOT_ROM = 4'h9
    } target_t;

    typedef enum logic [1:0] {
        DEC_IDLE = 2'b00,
        DEC_GRANT = 2'b01,
        DEC_FAULT = 2'b10
    } dec_state_t;
endpackage

// file: hw/unified_address_map_decoder.sv
`timescale 1ns/1ps
// Function
// RULE1 - One flat 32-bit, 4G byte space; no separate I/O space.
// RULE2 - Control register region reachable only by core in supervisor mode.
// RULE3 - Control registers at top: core block and peripheral block.
// RULE4 - External unit has 16-bit data, one SDRAM region, four async banks.
// RULE5 - Each async bank owns a fixed 1M byte segment.
// RULE6 - SDRAM size programmable up to 128M bytes.
// RULE7 - Track four SDRAM internal banks, one open row each.
// RULE8 - Instruction memory 48K, instructions only; 16K can be 4-way cache.
// RULE9 - Up to two data banks of 32K, each cache or SRAM.
// RULE10 - 4K scratchpad, data only, never cache.
// RULE11 - Boot ROM strap selects fetch start in boot ROM after reset.
// RULE12 - User access to control registers flags violation, never completes.
module unified_address_map_decoder #(
    parameter int DATA_BANKS = 2,
    parameter int ROW_BITS = addr_map_pkg::ROW_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic boot_rom_sel_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic write_i,
    input wire logic fetch_i,
    input wire logic periph_master_i,
    input wire logic supervisor_i,
    input wire logic [15:0] wdata_i,
    input wire logic [31:0] sdram_size_i,
    input wire logic instr_cache_en_i,
    input wire logic [1:0] data_cache_en_i,
    output logic ready_o,
    output logic grant_o,
    output logic [3:0] target_o,
    output logic [31:0] offset_o,
    output logic [1:0] async_bank_o,
    output logic [1:0] sdram_bank_o,
    output logic sdram_row_hit_o,
    output logic cache_path_o,
    output logic reg_write_o,
    output logic [15:0] ext_wdata_o,
    output logic violation_o,
    output logic decode_error_o,
    output logic [31:0] reset_fetch_addr_o
);
    initial begin
        if (DATA_BANKS < 1 || DATA_BANKS > 2) $error("DATA_BANKS 1..2");
        if (ROW_BITS < 1 || ROW_BITS > 16) $error("ROW_BITS 1..16");
    end

    function automatic logic in_rgn(input logic [31:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] len);
        in_rgn = (a >= base) && ((a - base) < len);
    endfunction

    // Strap pin, synchronised
    logic strap_meta_r, strap_sync_r, strap_done_r;
    logic [1:0] strap_age_r;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_meta_r <= 1'b0;
            strap_sync_r <= 1'b0;
        end else begin
            strap_meta_r <= boot_rom_sel_i;
            strap_sync_r <= strap_meta_r;
        end
    end

    // Caught once after release; later strap changes are ignored
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_done_r <= 1'b0;
            strap_age_r <= 2'b00;
            reset_fetch_addr_o <= addr_map_pkg::RESET_FETCH_ROM;
        end else if (!strap_done_r) begin
            strap_age_r <= {strap_age_r[0], 1'b1};
            // Wait until the synchroniser holds a real pin sample
            if (strap_age_r[1]) begin
                strap_done_r <= 1'b1;
                reset_fetch_addr_o <= strap_sync_r ?
                    addr_map_pkg::RESET_FETCH_ROM :
                    addr_map_pkg::RESET_FETCH_EXT; // RULE11
            end
        end
    end

    localparam int ASYNC_BANKS_C = addr_map_pkg::ASYNC_BANKS;

    // Combinational decode of the whole 32-bit space
    addr_map_pkg::target_t tgt;
    logic [31:0] base;
    logic [31:0] sd_lim;
    logic deny;
    logic fault;
    always_comb begin
        tgt = addr_map_pkg::TGT_NONE;
        base = 32'h0000_0000;
        deny = 1'b0;
        fault = 1'b0;
        sd_lim = (sdram_size_i > addr_map_pkg::SDRAM_MAX_BYTES) ?
            addr_map_pkg::SDRAM_MAX_BYTES : sdram_size_i; // RULE6
        // RULE1
        if (in_rgn(addr_i, addr_map_pkg::SDRAM_BASE, sd_lim)) begin
            tgt = addr_map_pkg::TGT_SDRAM;
            base = addr_map_pkg::SDRAM_BASE;
        end else if (in_rgn(addr_i, addr_map_pkg::ASYNC_BASE,
                addr_map_pkg::ASYNC_SEG_BYTES * 32'(ASYNC_BANKS_C))) begin
            tgt = addr_map_pkg::TGT_ASYNC; // RULE4
            base = addr_map_pkg::ASYNC_BASE;
        end else if (in_rgn(addr_i, addr_map_pkg::BOOT_ROM_BASE,
                addr_map_pkg::BOOT_ROM_BYTES)) begin
            tgt = addr_map_pkg::TGT_BOOT_ROM;
            base = addr_map_pkg::BOOT_ROM_BASE;
            deny = write_i;
        end else if (in_rgn(addr_i, addr_map_pkg::DATA_A_BASE,
                addr_map_pkg::DATA_BANK_BYTES)) begin
            tgt = addr_map_pkg::TGT_DATA_A;
            base = addr_map_pkg::DATA_A_BASE;
            deny = fetch_i; // RULE9
        end else if (DATA_BANKS == 2 && in_rgn(addr_i,
                addr_map_pkg::DATA_B_BASE,
                addr_map_pkg::DATA_BANK_BYTES)) begin
            tgt = addr_map_pkg::TGT_DATA_B;
            base = addr_map_pkg::DATA_B_BASE;
            deny = fetch_i; // RULE9
        end else if (in_rgn(addr_i, addr_map_pkg::INSTR_BASE,
                addr_map_pkg::INSTR_BYTES)) begin
            tgt = addr_map_pkg::TGT_INSTR;
            base = addr_map_pkg::INSTR_BASE;
            // Core fetch only; DMA fill path not modelled here
            deny = !fetch_i || periph_master_i; // RULE8
        end else if (in_rgn(addr_i, addr_map_pkg::SCRATCH_BASE,
                addr_map_pkg::SCRATCH_BYTES)) begin
            tgt = addr_map_pkg::TGT_SCRATCH;
            base = addr_map_pkg::SCRATCH_BASE;
            deny = fetch_i || periph_master_i; // RULE10
        end else if (in_rgn(addr_i, addr_map_pkg::PERIPH_REG_BASE,
                addr_map_pkg::REG_BLOCK_BYTES)) begin
            tgt = addr_map_pkg::TGT_PERIPH_REG; // RULE3
            base = addr_map_pkg::PERIPH_REG_BASE;
        end else if (in_rgn(addr_i, addr_map_pkg::CORE_REG_BASE,
                addr_map_pkg::REG_BLOCK_BYTES)) begin
            tgt = addr_map_pkg::TGT_CORE_REG; // RULE3
            base = addr_map_pkg::CORE_REG_BASE;
        end
        // Peripheral masters see the register region as reserved
        if ((tgt == addr_map_pkg::TGT_CORE_REG ||
             tgt == addr_map_pkg::TGT_PERIPH_REG) && periph_master_i) begin
            tgt = addr_map_pkg::TGT_NONE; // RULE2
        end
        if ((tgt == addr_map_pkg::TGT_CORE_REG ||
             tgt == addr_map_pkg::TGT_PERIPH_REG) && !supervisor_i) begin
            fault = 1'b1; // RULE2 RULE12
        end
    end

    logic [31:0] off;
    assign off = addr_i - base;

    // Request/answer sequencer: one-cycle answer
    addr_map_pkg::dec_state_t state_r, state_nxt;
    always_comb begin
        case (state_r)
            addr_map_pkg::DEC_IDLE: begin
                if (!req_i) begin
                    state_nxt = addr_map_pkg::DEC_IDLE;
                end else if (fault) begin
                    state_nxt = addr_map_pkg::DEC_FAULT;
                end else begin
                    state_nxt = addr_map_pkg::DEC_GRANT;
                end
            end
            default: begin
                state_nxt = addr_map_pkg::DEC_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= addr_map_pkg::DEC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end
    assign ready_o = (state_r == addr_map_pkg::DEC_IDLE);

    logic take;
    assign take = req_i && ready_o;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_o <= 1'b0;
            target_o <= 4'h0;
            offset_o <= 32'h0000_0000;
            async_bank_o <= 2'h0;
            cache_path_o <= 1'b0;
            reg_write_o <= 1'b0;
            ext_wdata_o <= 16'h0000;
            violation_o <= 1'b0;
            decode_error_o <= 1'b0;
        end else begin
            grant_o <= take && !fault && !deny &&
                tgt != addr_map_pkg::TGT_NONE;
            violation_o <= take && fault; // RULE12
            decode_error_o <= take && !fault &&
                (deny || tgt == addr_map_pkg::TGT_NONE);
            // Faulted register access never writes
            reg_write_o <= take && !fault && write_i &&
                (tgt == addr_map_pkg::TGT_CORE_REG ||
                 tgt == addr_map_pkg::TGT_PERIPH_REG); // RULE12
            if (take) begin
                // Refused accesses steer nowhere
                target_o <= (fault || deny) ? 4'h0 : 4'(tgt);
                offset_o <= off;
                async_bank_o <= off[21:20]; // RULE5
                ext_wdata_o <= wdata_i; // RULE4
                cache_path_o <=
                    (tgt == addr_map_pkg::TGT_INSTR && instr_cache_en_i &&
                     in_rgn(addr_i, addr_map_pkg::INSTR_CACHE_BASE,
                            addr_map_pkg::INSTR_CACHE_BYTES)) ||
                    (tgt == addr_map_pkg::TGT_DATA_A && data_cache_en_i[0]) ||
                    (tgt == addr_map_pkg::TGT_DATA_B &&
                     data_cache_en_i[1]); // RULE8 RULE9 RULE10
            end
        end
    end

    // Open row per SDRAM internal bank; bank from offset bits 26:25
    logic [addr_map_pkg::SDRAM_INT_BANKS-1:0] row_open_r;
    logic [ROW_BITS-1:0] open_row_r [addr_map_pkg::SDRAM_INT_BANKS];
    logic [1:0] sb;
    logic [ROW_BITS-1:0] row;
    assign sb = off[26:25];
    assign row = off[ROW_BITS+10:11];
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            row_open_r <= '0;
            sdram_bank_o <= 2'h0;
            sdram_row_hit_o <= 1'b0;
            for (int i = 0; i < addr_map_pkg::SDRAM_INT_BANKS; i++) begin
                open_row_r[i] <= '0;
            end
        end else if (take && !fault && tgt == addr_map_pkg::TGT_SDRAM) begin
            sdram_bank_o <= sb;
            sdram_row_hit_o <= row_open_r[sb] && open_row_r[sb] == row;
            row_open_r[sb] <= 1'b1; // RULE7
            open_row_r[sb] <= row; // RULE7
        end else if (take) begin
            sdram_row_hit_o <= 1'b0;
        end
    end
endmodule

// file: dv/unified_address_map_decoder_checker.sv
`timescale 1ns/1ps
module unified_address_map_decoder_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic fetch_i,
    input wire logic periph_master_i,
    input wire logic supervisor_i,
    input wire logic ready_o,
    input wire logic grant_o,
    input wire logic [3:0] target_o,
    input wire logic [31:0] offset_o,
    input wire logic [1:0] async_bank_o,
    input wire logic [1:0] sdram_bank_o,
    input wire logic reg_write_o,
    input wire logic violation_o,
    input wire logic decode_error_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence take_s;
        req_i && ready_o;
    endsequence
    // Top 4M holds both register blocks
    sequence reg_take_s;
        take_s ##0 (addr_i[31:22] == 10'h3FF);
    endsequence
    AST_ANSWER: assert property (take_s |=>
        $onehot({grant_o, violation_o, decode_error_o}) && !ready_o)
        else $error("no single answer after a take");
    AST_PULSE: assert property (grant_o |=> !grant_o)
        else $error("grant held past one cycle");
    AST_USER_REG: assert property (reg_take_s ##0
        (!periph_master_i && !supervisor_i) |=>
        violation_o && !grant_o && !reg_write_o)
        else $error("user register access not flagged");
    AST_PERIPH_REG: assert property (reg_take_s ##0
        (periph_master_i) |=> decode_error_o && !grant_o)
        else $error("peripheral master reached registers");
    AST_SUPER_REG: assert property (reg_take_s ##0
        (!periph_master_i && supervisor_i) |=>
        grant_o && (target_o == 4'h5 || target_o == 4'h6))
        else $error("supervisor register access refused");
    AST_ASYNC_BANK: assert property (grant_o && target_o == 4'h8
        |-> async_bank_o == offset_o[21:20] && offset_o[31:22] == 10'h0)
        else $error("async bank not from 1M segment");
    AST_SDRAM_BANK: assert property (grant_o && target_o == 4'h7
        |-> sdram_bank_o == offset_o[26:25])
        else $error("sdram bank field wrong");
    AST_SCRATCH_FETCH: assert property (take_s ##0 (fetch_i &&
        addr_i[31:20] == 12'hFFB) |=> decode_error_o)
        else $error("fetch from scratchpad accepted");
    AST_FAULT_QUIET: assert property ((violation_o ||
        decode_error_o) |-> target_o == 4'h0 && !reg_write_o)
        else $error("faulted access left side effects");
endmodule
bind unified_address_map_decoder unified_address_map_decoder_checker
    chk_inst (.clk_sys_i, .rst_n_i, .req_i, .addr_i, .fetch_i,
    .periph_master_i, .supervisor_i, .ready_o, .grant_o, .target_o,
    .offset_o, .async_bank_o, .sdram_bank_o, .reg_write_o,
    .violation_o, .decode_error_o);

// file: dv/ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic clk_sys_i,
    input wire logic take_i,
    input wire logic write_i,
    input wire logic grant_i,
    input wire logic [3:0] target_i,
    input wire logic [1:0] bank_i,
    input wire logic [15:0] data_i,
    input wire logic [1:0] rd_bank_i,
    output logic [15:0] rd_o
);
    logic wr_r = 1'b0;
    // One 16-bit word per bank; rd_o reads the word of bank rd_bank_i
    logic [15:0] mem_r [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
    always_ff @(posedge clk_sys_i) begin
        wr_r <= take_i && write_i;
        if (grant_i && wr_r && target_i == 4'h8) begin
            mem_r[bank_i] <= data_i;
        end
    end
    assign rd_o = mem_r[rd_bank_i];
endmodule

// file: dv/unified_address_map_decoder_tb.sv
`timescale 1ns/1ps
module unified_address_map_decoder_tb;
    typedef struct packed {
        logic [31:0] a;
        logic [3:0] m;
        logic [3:0] t;
        logic [1:0] r;
        logic [31:0] o;
    } row_t;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strap = 1'b1;
    logic req = 1'b0;
    logic fetch = 1'b0, wr = 1'b0, pm = 1'b0, sup = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0;
    logic [31:0] size = 32'h0100_0000;
    logic ice = 1'b0;
    logic [1:0] dce = 2'h0;
    logic cpath;
    logic ready, grant, viol, derr, hit, regwr;
    logic [3:0] tgt;
    logic [31:0] off, rfa;
    logic [1:0] sbank, abank;
    logic [15:0] ewd, mword;
    int miscompares = 0;
    int n_compared = 0;
    int n_cycles = 0;
    row_t rows [20];
    logic [31:0] ha [4] = '{32'h800, 32'h0200_1000, 32'h800, 32'h1000};
    logic [1:0] hb [4] = '{2'h0, 2'h1, 2'h0, 2'h0};
    unified_address_map_decoder unified_address_map_decoder_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .boot_rom_sel_i(strap),
        .req_i(req), .addr_i(addr), .write_i(wr), .fetch_i(fetch),
        .periph_master_i(pm), .supervisor_i(sup), .wdata_i(wdata),
        .sdram_size_i(size), .instr_cache_en_i(ice),
        .data_cache_en_i(dce), .ready_o(ready), .grant_o(grant),
        .target_o(tgt), .offset_o(off), .async_bank_o(abank),
        .sdram_bank_o(sbank), .sdram_row_hit_o(hit), .cache_path_o(cpath),
        .reg_write_o(regwr), .ext_wdata_o(ewd), .violation_o(viol),
        .decode_error_o(derr), .reset_fetch_addr_o(rfa));
    ext_mem_model ext_mem_model_inst (.clk_sys_i(clk_sys_i),
        .take_i(req && ready), .write_i(wr), .grant_i(grant),
        .target_i(tgt), .bank_i(abank), .data_i(ewd),
        .rd_bank_i(2'h2), .rd_o(mword));
    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic report_and_stop();
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        n_cycles++;
        // Tests need about 90 cycles
        if (n_cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic go(input logic [31:0] a, input logic [3:0] m);
        @(posedge clk_sys_i);
        #1;
        {fetch, wr, pm, sup} = m;
        addr = a;
        wdata = a[15:0] ^ 16'h5A5A;
        req = 1'b1;
        @(posedge clk_sys_i);
        #1;
        req = 1'b0;
    endtask
    initial begin
        rows = '{'{32'h100, 4'h1, 4'h7, 2'h0, 32'h100},
            '{32'h00FF_FFFE, 4'h5, 4'h7, 2'h0, 32'h00FF_FFFE},
            '{32'h0100_0000, 4'h1, 4'h0, 2'h2, 32'h0},
            '{32'h2020_0010, 4'h5, 4'h8, 2'h0, 32'h0020_0010},
            '{32'h203F_FFFE, 4'h3, 4'h8, 2'h0, 32'h003F_FFFE},
            '{32'h2040_0000, 4'h1, 4'h0, 2'h2, 32'h0},
            '{32'h4000_0000, 4'h1, 4'h0, 2'h2, 32'h0},
            '{32'hFF80_0000, 4'h1, 4'h2, 2'h0, 32'h0},
            '{32'hFF90_7FFE, 4'h7, 4'h3, 2'h0, 32'h7FFE},
            '{32'hFFA0_BFFE, 4'h9, 4'h1, 2'h0, 32'hBFFE},
            '{32'hFFA0_0000, 4'h5, 4'h0, 2'h2, 32'h0},
            '{32'hFFB0_0FFE, 4'h1, 4'h4, 2'h0, 32'hFFE},
            '{32'hFFB0_0FFE, 4'h9, 4'h0, 2'h2, 32'h0},
            '{32'hFFB0_1000, 4'h1, 4'h0, 2'h2, 32'h0},
            '{32'hFFE0_0000, 4'h5, 4'h5, 2'h0, 32'h0},
            '{32'hFFC0_0004, 4'h1, 4'h6, 2'h0, 32'h4},
            '{32'hFFC0_0004, 4'h4, 4'h0, 2'h1, 32'h0},
            '{32'hFFE0_0000, 4'h3, 4'h0, 2'h2, 32'h0},
            '{32'hEF00_0000, 4'h5, 4'h0, 2'h2, 32'h0},
            '{32'hEF00_0010, 4'h9, 4'h9, 2'h0, 32'h10}};
        repeat (12) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        chk("ready", 1'b1, ready);
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("fetch_rom", 32'hEF00_0000, rfa);
        foreach (rows[i]) begin
            go(rows[i].a, rows[i].m);
            chk("grant", rows[i].r == 2'h0, grant);
            chk("violation", rows[i].r == 2'h1, viol);
            chk("decode_error", rows[i].r == 2'h2, derr);
            chk("target", rows[i].t, tgt);
            chk("reg_write", rows[i].t inside {4'h5, 4'h6} &&
                rows[i].m[2], regwr);
            if (rows[i].r == 2'h0) chk("offset", rows[i].o, off);
        end
        chk("ext_word", 16'h5A4A, mword);
        size = 32'h0800_0000;
        foreach (ha[i]) begin
            go(ha[i], 4'h1);
            chk("sdram_bank", hb[i], sbank);
            chk("row_hit", i == 2, hit);
        end
        size = 32'hFFFF_FFFF;
        go(32'h07FF_FFFE, 4'h1);
        chk("clamp_in", 1'b1, grant);
        go(32'h0800_0000, 4'h1);
        chk("clamp_out", 1'b1, derr);
        ice = 1'b1;
        dce = 2'h2;
        go(32'hFFA0_8000, 4'h9);
        chk("cache_instr", 1'b1, cpath);
        go(32'hFFA0_0000, 4'h9);
        chk("sram_instr", 1'b0, cpath);
        go(32'hFF90_0000, 4'h1);
        chk("cache_data_b", 1'b1, cpath);
        go(32'hFFB0_0000, 4'h1);
        chk("scratch_nc", 1'b0, cpath);
        go(32'hFF80_0000, 4'h1);
        chk("sram_data_a", 1'b0, cpath);
        // Hold the request into the busy cycle; it must be refused
        @(posedge clk_sys_i);
        #1;
        {fetch, wr, pm, sup} = 4'h1;
        addr = 32'hFF80_0010;
        req = 1'b1;
        @(posedge clk_sys_i);
        #1;
        addr = 32'hFFB0_0000;
        chk("grant_a", 1'b1, grant);
        chk("ready_low", 1'b0, ready);
        @(posedge clk_sys_i);
        #1;
        req = 1'b0;
        chk("refused", 1'b0, grant);
        chk("target_hold", 4'h2, tgt);
        strap = 1'b0;
        rst_n_i = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        #1;
        chk("fetch_ext", 32'h2000_0000, rfa);
        report_and_stop();
    end
endmodule
